// *** ehl_defs.vh ***
// shared constants for the embedded link controllers
`ifndef EHL_DEFS_VH
`define EHL_DEFS_VH
`define EHL_FIFO_AW 7
`define EHL_FIFO_MAX 128
`define EHL_FIFO_STEP 16
`define EHL_CLK_NS 40
`define EHL_SPACE_SLOW_NS 160
`define EHL_SPACE_FAST_NS 80
`define EHL_SPACE_SLOW_CYC ((`EHL_SPACE_SLOW_NS + `EHL_CLK_NS - 1) / `EHL_CLK_NS)
`define EHL_SPACE_FAST_CYC ((`EHL_SPACE_FAST_NS + `EHL_CLK_NS - 1) / `EHL_CLK_NS)
`define EHL_FLAG 8'h7E
`define EHL_ONES 8'hFF
`define EHL_ABORT_BYTE 8'hFE
`define EHL_ALLCALL 8'hFF
`define EHL_CRC_INIT 16'hFFFF
`define EHL_CRC_POLY 16'h8408
`define EHL_CRC_GOOD 16'hF0B8
`define EHL_GA_PAT 15'h3F7F
`define EHL_MIN_BITS 6'h19
`define EHL_GOOD_BITS 6'h20
`define EHL_SKIP56_BIT 3'h7
`define EHL_NAT_FIRST 3'h3
`define EHL_ST_DATA 2'h0
`define EHL_ST_GOOD 2'h1
`define EHL_ST_BAD 2'h2
`define EHL_ST_ABORT 2'h3
`define EHL_EV_W 10
`define EHL_EV_RXNF 0
`define EHL_EV_RXOV 1
`define EHL_EV_TXLOW 2
`define EHL_EV_TXUR 3
`define EHL_EV_TXEOP 4
`define EHL_EV_RXEOP 5
`define EHL_EV_RXBAD 6
`define EHL_EV_RXABT 7
`define EHL_EV_GA 8
`define EHL_EV_EOPRD 9
`endif

// *** ehl_fifo.v ***
// byte fifo with a depth selectable in steps of sixteen entries
`timescale 1ns/1ns
`include "ehl_defs.vh"
module ehl_fifo #(
  parameter DW = 8,
  parameter AW = `EHL_FIFO_AW
)(
  // clock, reset, enable
  input wire mclk_in,
  input wire nrst_in,
  input wire ce_in,
  // depth code: depth = (code + 1) * 16
  input wire [2:0] depth_in,
  // write side
  input wire wr_in,
  input wire [DW-1:0] wdata_in,
  // read side, data valid whenever not empty
  input wire rd_in,
  output wire [DW-1:0] rdata_out,
  // state
  output wire full_out,
  output wire empty_out,
  output wire [AW:0] level_out
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire [AW:0] depth = {({1'b0, depth_in} + 4'h1), 4'h0};
  wire do_wr = wr_in & (cnt_q < depth);
  wire do_rd = rd_in & (cnt_q != {(AW+1){1'b0}});

  assign rdata_out = mem[rp_q];
  assign full_out = (cnt_q >= depth);
  assign empty_out = (cnt_q == {(AW+1){1'b0}});
  assign level_out = cnt_q;

  // storage; no reset needed on the array itself
  always @(posedge mclk_in)
  begin
    if (ce_in && do_wr)
      mem[wp_q] <= wdata_in;
  end

  // pointers wrap at the selected depth, not at the array size
  always @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else if (ce_in)
    begin
      if (do_wr)
        wp_q <= ({1'b0, wp_q} + 1'b1 >= depth) ? {AW{1'b0}} : wp_q + 1'b1;
      if (do_rd)
        rp_q <= ({1'b0, rp_q} + 1'b1 >= depth) ? {AW{1'b0}} : rp_q + 1'b1;
      if (do_wr && !do_rd)
        cnt_q <= cnt_q + 1'b1;
      else if (do_rd && !do_wr)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// *** ehl_framer_model.sv ***
// framer timing model: bit strobe, slot and bit counters, receive line
`timescale 1ns/1ns
module ehl_framer_model (
  // clock and reset
  input wire mclk_in,
  input wire nrst_in,
  // framer side
  output reg fr_stb_out,
  output reg [4:0] fr_slot_out,
  output reg [2:0] fr_bit_out,
  output reg rx_line_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // a bit lasts two clocks; 32 timeslots wrap with the counter width
  always @(posedge mclk_in)
  begin
    fr_stb_out <= nrst_in & ~fr_stb_out;
    if (!nrst_in)
    begin
      {fr_slot_out, fr_bit_out} <= 8'h0;
      rx_line_out <= 1'b0;
    end
    else if (fr_stb_out)
    begin
      {fr_slot_out, fr_bit_out} <= {fr_slot_out, fr_bit_out} + 8'h1;
      // toggling line, so a leak past the loopback shows
      rx_line_out <= ~rx_line_out;
    end
  end
endmodule

// *** ehl_monitor.sv ***
// checker on the ports of the three-controller top
`timescale 1ns/1ns
module ehl_monitor (
  // clock, reset, framer timing
  input wire mclk_in,
  input wire nrst_in,
  input wire fr_stb_in,
  input wire [4:0] fr_slot_in,
  // host side
  input wire [14:0] tx_slot_in,
  input wire [2:0] tx_wr_in,
  input wire [2:0] rx_rd_in,
  input wire [8:0] tx_depth_in,
  input wire [29:0] ev_mask_in,
  input wire [23:0] tx_level_out,
  input wire [23:0] rx_level_out,
  input wire [5:0] rx_stat_out,
  // line side and events
  input wire [2:0] tx_line_out,
  input wire [2:0] tx_take_out,
  input wire [29:0] ev_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////////////////////////
  // tx fill rises and rx fill falls only after a host access one cycle earlier
  sequence s_tx_grow;
    tx_level_out[7:0] > $past(tx_level_out[7:0]);
  endsequence
  sequence s_rx_shrink;
    rx_level_out[7:0] < $past(rx_level_out[7:0]);
  endsequence
  chk_tx_grow: assert property (s_tx_grow |-> $past(tx_wr_in[0])) else $error("tx fill rose without write");
  chk_rx_shrink: assert property (s_rx_shrink |-> $past(rx_rd_in[0])) else $error("rx fill fell without read");
  chk_eop_read: assert property (s_rx_shrink ##0 rx_stat_out[1:0] != 2'h0 |-> ev_out[9] == ev_mask_in[9])
    else $error("end entry read without event");
  chk_ev_pulse: assert property (ev_out[4] |=> !ev_out[4]) else $error("tx end event longer than one cycle");
  chk_line_hold: assert property (!$past(tx_take_out[0]) |-> $stable(tx_line_out[0])) else $error("line moved off take");
  chk_max_fill: assert property (tx_level_out[7:0] <= 8'h80) else $error("tx fill above maximum");
  chk_depth_cap: assert property (tx_level_out[7:0] <= (({5'h0, tx_depth_in[2:0]} + 8'h1) << 4))
    else $error("tx fill above depth");
  chk_take_slot: assert property (tx_take_out[0] |-> fr_stb_in && fr_slot_in == tx_slot_in[4:0])
    else $error("take outside own slot");
endmodule
bind ehl_top ehl_monitor u_mon (.*);

// *** ehl_top.v ***
// three embedded link controllers: flags, check sequence, stuffing, fifos, events
`timescale 1ns/1ns
`include "ehl_defs.vh"
module ehl_chan (
  // clock, reset, enable
  input wire mclk_in,
  input wire nrst_in,
  input wire ce_in,
  // framer bit timing and receive stream
  input wire fr_stb_in,
  input wire fr_e1_in,
  input wire [4:0] fr_slot_in,
  input wire [2:0] fr_bit_in,
  input wire fr_fdl_in,
  input wire fr_nfas_in,
  input wire rx_line_in,
  // configuration
  input wire dl_sel_in,
  input wire [4:0] nat_mask_in,
  input wire [4:0] tx_slot_in,
  input wire [4:0] rx_slot_in,
  input wire tx_56_in,
  input wire rx_56_in,
  input wire tx_en_in,
  input wire rx_en_in,
  input wire flag_idle_in,
  input wire fcs_inh_in,
  input wire cnt_en_in,
  input wire [15:0] cnt_len_in,
  input wire [1:0] addr_mode_in,
  input wire [15:0] addr_in,
  input wire lb_tx2rx_in,
  input wire lb_rx2tx_in,
  input wire fast_acc_in,
  input wire [2:0] tx_depth_in,
  input wire [2:0] rx_depth_in,
  input wire [7:0] tx_low_in,
  input wire [7:0] rx_nf_in,
  input wire [`EHL_EV_W-1:0] ev_mask_in,
  input wire abort_cmd_in,
  // host fifo access
  input wire tx_wr_in,
  input wire [7:0] tx_data_in,
  input wire tx_eop_in,
  input wire rx_rd_in,
  output reg [7:0] rx_data_out,
  output reg [1:0] rx_stat_out,
  output reg [15:0] rx_fcs_out,
  output wire [7:0] tx_level_out,
  output wire [7:0] rx_level_out,
  // framer transmit side and events
  output reg tx_line_out,
  output wire tx_take_out,
  output reg [`EHL_EV_W-1:0] ev_out
);
  localparam [5:0] T_IDLE = 6'h01, T_OPEN = 6'h02, T_DATA = 6'h04;
  localparam [5:0] T_FCS = 6'h08, T_CLOSE = 6'h10, T_ABRT = 6'h20;

  reg [5:0] tst_q;
  reg [7:0] tsh_q, fcsh_q, tlow_prev_q, rnf_prev_q;
  reg [2:0] tbc_q, tone_q, rone_q, rbb_q, sp_q;
  reg [15:0] tcrc_q, tcnt_q, rcrc_q;
  reg tlast_q, thalf_q, abort_pend_q, rin_q, rdrop_q, ov_q, rx_last_q;
  reg [14:0] hist_q;
  reg [6:0] dl_q;
  reg [2:0] dn_q;
  reg [5:0] rnb_q;
  reg [7:0] rsh_q, h1_q, h2_q, ob_q;
  reg [`EHL_EV_W-1:0] ev;
  reg tpop, rwr;
  reg [9:0] rwdata;
  wire [8:0] tf_rdata;
  wire [9:0] rf_rdata;
  wire tf_full, tf_empty, rf_full, rf_empty;
  wire [7:0] tf_lvl, rf_lvl;

  // timeslot, national bit or data link bit selection
  function take;
    input [4:0] slot;
    input is56;
    begin
      if (dl_sel_in)
        take = fr_e1_in ? (fr_slot_in == 5'h00 && fr_nfas_in && fr_bit_in >= `EHL_NAT_FIRST &&
               nat_mask_in[fr_bit_in - `EHL_NAT_FIRST]) : fr_fdl_in;
      else
        take = (fr_slot_in == slot) && !fr_fdl_in &&
               !(is56 && !fr_e1_in && fr_bit_in == `EHL_SKIP56_BIT);
    end
  endfunction

  // reflected crc step, one bit
  function [15:0] crc_bit;
    input [15:0] c;
    input b;
    begin
      crc_bit = {1'b0, c[15:1]} ^ ((c[0] ^ b) ? `EHL_CRC_POLY : 16'h0000);
    end
  endfunction

  wire tb = fr_stb_in & tx_en_in & take(tx_slot_in, tx_56_in);
  wire tstuff = (tone_q == 3'h5); // a run of ones may end just before the closing flag
  wire tbit = tstuff ? 1'b0 : tsh_q[0];
  wire rb = lb_tx2rx_in ? tb : (fr_stb_in & rx_en_in & take(rx_slot_in, rx_56_in));
  wire rbit = lb_tx2rx_in ? tbit : rx_line_in;
  wire [15:0] tcrc_d = crc_bit(tcrc_q, tsh_q[0]);
  wire [7:0] idle_byte = flag_idle_in ? `EHL_FLAG : `EHL_ONES;
  wire acc_ok = (sp_q == 3'h0);
  wire hwr = tx_wr_in & acc_ok;
  wire hrd = rx_rd_in & acc_ok & !rf_empty;
  wire [31:0] space_w = fast_acc_in ? `EHL_SPACE_FAST_CYC : `EHL_SPACE_SLOW_CYC;
  wire [2:0] space = space_w[2:0];

  assign tx_take_out = tb;
  assign tx_level_out = tf_lvl;
  assign rx_level_out = rf_lvl;

  // transmit fifo holds data plus end-of-packet mark
  ehl_fifo #(.DW(9)) u_txf (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(ce_in), .depth_in(tx_depth_in),
    .wr_in(hwr & !tf_full), .wdata_in({tx_eop_in, tx_data_in}), .rd_in(tpop & ce_in & tb),
    .rdata_out(tf_rdata), .full_out(tf_full), .empty_out(tf_empty), .level_out(tf_lvl)
  );

  // receive fifo holds data plus a two-bit status
  ehl_fifo #(.DW(10)) u_rxf (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(ce_in), .depth_in(rx_depth_in),
    .wr_in(rwr & ce_in & rb), .wdata_in(rwdata), .rd_in(hrd),
    .rdata_out(rf_rdata), .full_out(rf_full), .empty_out(rf_empty), .level_out(rf_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmitter: byte-end decisions are combinational, bit shifting registered
  reg [5:0] tst_d;
  reg [7:0] tload;
  reg tload_en;
  always @*
  begin
    tst_d = tst_q;
    tload = idle_byte;
    tload_en = 1'b0;
    tpop = 1'b0;
    ev = {`EHL_EV_W{1'b0}};
    if (!tstuff && tbc_q == 3'h7)
    begin
      tload_en = 1'b1;
      case (tst_q)
        T_IDLE:
          if (!tf_empty)
          begin
            tst_d = T_OPEN;
            tload = `EHL_FLAG;
          end
        T_OPEN:
          begin
            tst_d = T_DATA;
            tpop = 1'b1;
            tload = tf_rdata[7:0];
          end
        T_DATA:
          if (abort_pend_q || (!tlast_q && tf_empty))
          begin
            tst_d = T_ABRT;
            tload = `EHL_ABORT_BYTE;
            ev[`EHL_EV_TXUR] = !abort_pend_q;
          end
          else if (tlast_q)
          begin
            tst_d = fcs_inh_in ? T_CLOSE : T_FCS;
            tload = fcs_inh_in ? `EHL_FLAG : ~tcrc_d[7:0];
          end
          else
          begin
            tpop = 1'b1;
            tload = tf_rdata[7:0];
          end
        T_FCS:
          begin
            tst_d = thalf_q ? T_CLOSE : T_FCS;
            tload = thalf_q ? `EHL_FLAG : fcsh_q;
          end
        T_CLOSE:
          begin
            tst_d = T_IDLE;
            ev[`EHL_EV_TXEOP] = 1'b1;
          end
        T_ABRT:
          tst_d = T_IDLE;
        default:
          tst_d = T_IDLE;
      endcase
    end
  end

  // transmit state, shift register, crc and byte counting
  always @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      tst_q <= T_IDLE;
      tsh_q <= `EHL_ONES;
      tbc_q <= 3'h0;
      tone_q <= 3'h0;
      tcrc_q <= `EHL_CRC_INIT;
      tcnt_q <= 16'h0000;
      tlast_q <= 1'b0;
      thalf_q <= 1'b0;
      fcsh_q <= 8'h00;
      abort_pend_q <= 1'b0;
      tx_line_out <= 1'b1;
    end
    else if (ce_in)
    begin
      if (abort_cmd_in)
        abort_pend_q <= 1'b1;
      if (tb)
      begin
        tx_line_out <= lb_rx2tx_in ? rx_last_q : tbit;
        if (tstuff)
          tone_q <= 3'h0;
        else
        begin
          tone_q <= ((tst_q == T_DATA || tst_q == T_FCS) && tsh_q[0]) ? tone_q + 3'h1 : 3'h0;
          tbc_q <= tbc_q + 3'h1;
          tsh_q <= {1'b1, tsh_q[7:1]};
          if (tst_q == T_DATA)
            tcrc_q <= tcrc_d;
          if (tload_en)
          begin
            tst_q <= tst_d;
            tsh_q <= tload;
            if (tst_d == T_ABRT || tst_q == T_IDLE)
              abort_pend_q <= abort_cmd_in;
            if (tst_q == T_DATA && tst_d == T_FCS)
            begin
              fcsh_q <= ~tcrc_d[15:8];
              thalf_q <= 1'b0;
            end
            if (tst_q == T_FCS)
              thalf_q <= 1'b1;
            if (tst_q == T_OPEN)
            begin
              tcrc_q <= `EHL_CRC_INIT;
              tcnt_q <= 16'h0000;
            end
            else if (tpop)
              tcnt_q <= tcnt_q + 16'h0001;
            if (tpop)
              tlast_q <= tf_rdata[8] | (cnt_en_in && (tst_q == T_OPEN ? 16'h0000 : tcnt_q + 16'h0001)
                         == cnt_len_in);
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver: destuffing with a seven-bit lag so flag bits never reach the byte path
  wire rflag = !rbit && rone_q == 3'h6;
  wire rstuf = !rbit && rone_q == 3'h5;
  wire rabt = rbit && rone_q == 3'h6;
  wire commit = rin_q && !rdrop_q && !rflag && !rstuf && !rabt && dn_q == 3'h7;
  wire [7:0] rbyte = {dl_q[0], rsh_q[7:1]};
  wire bytedone = commit && rbb_q == 3'h7;
  wire [2:0] bnum = rnb_q[5:3];
  wire addr_bad = (bnum == 3'h0 && addr_mode_in != 2'h0 && rbyte != addr_in[7:0] && rbyte != `EHL_ALLCALL) ||
                  (bnum == 3'h1 && addr_mode_in == 2'h2 && rbyte != addr_in[15:8] && rbyte != `EHL_ALLCALL);
  wire fend = rflag && rin_q && !rdrop_q && rnb_q >= `EHL_MIN_BITS;
  wire fbad = rnb_q < `EHL_GOOD_BITS || rbb_q != 3'h0 || rcrc_q != `EHL_CRC_GOOD;

  // fifo write: delayed data byte, or the closing entry with its status
  always @*
  begin
    rwr = 1'b0;
    rwdata = {`EHL_ST_DATA, ob_q};
    if (bytedone && bnum >= 3'h3 && ov_q)
      rwr = 1'b1;
    else if (fend && ov_q)
    begin
      rwr = 1'b1;
      rwdata = {fbad ? `EHL_ST_BAD : `EHL_ST_GOOD, ob_q};
    end
    else if (rabt && rin_q && !rdrop_q && ov_q)
    begin
      rwr = 1'b1;
      rwdata = {`EHL_ST_ABORT, ob_q};
    end
  end

  // receive bit processing
  always @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      hist_q <= 15'h0000;
      rone_q <= 3'h0;
      rin_q <= 1'b0;
      rdrop_q <= 1'b0;
      dl_q <= 7'h00;
      dn_q <= 3'h0;
      rsh_q <= 8'h00;
      rbb_q <= 3'h0;
      rnb_q <= 6'h00;
      rcrc_q <= `EHL_CRC_INIT;
      h1_q <= 8'h00;
      h2_q <= 8'h00;
      ob_q <= 8'h00;
      ov_q <= 1'b0;
      rx_last_q <= 1'b1;
      rx_fcs_out <= 16'h0000;
    end
    else if (ce_in && rb)
    begin
      rx_last_q <= rbit;
      hist_q <= {hist_q[13:0], rbit};
      rone_q <= rbit ? ((rone_q == 3'h7) ? 3'h7 : rone_q + 3'h1) : 3'h0;
      if (rflag || rabt)
      begin
        // a flag opens a frame; an abort hunts for the next flag
        rin_q <= rflag;
        rdrop_q <= 1'b0;
        dn_q <= 3'h0;
        rbb_q <= 3'h0;
        rnb_q <= 6'h00;
        rcrc_q <= `EHL_CRC_INIT;
        ov_q <= 1'b0;
        if (fend)
          rx_fcs_out <= {h1_q, h2_q};
      end
      else if (!rstuf && rin_q)
      begin
        dl_q <= {rbit, dl_q[6:1]};
        if (dn_q != 3'h7)
          dn_q <= dn_q + 3'h1;
        if (commit)
        begin
          rsh_q <= {dl_q[0], rsh_q[7:1]};
          rbb_q <= rbb_q + 3'h1;
          rnb_q <= (rnb_q == 6'h3F) ? rnb_q : rnb_q + 6'h01;
          rcrc_q <= crc_bit(rcrc_q, dl_q[0]);
          if (bytedone)
          begin
            if (addr_bad)
              rdrop_q <= 1'b1;
            h1_q <= rbyte;
            h2_q <= h1_q;
            if (bnum >= 3'h2)
            begin
              ob_q <= h2_q;
              ov_q <= 1'b1;
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host access spacing and receive read-out
  always @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      sp_q <= 3'h0;
      rx_data_out <= 8'h00;
      rx_stat_out <= `EHL_ST_DATA;
    end
    else if (ce_in)
    begin
      // accesses closer than the selected spacing are ignored
      if ((tx_wr_in || rx_rd_in) && acc_ok)
        sp_q <= space - 3'h1;
      else if (!acc_ok)
        sp_q <= sp_q - 3'h1;
      if (hrd)
      begin
        rx_data_out <= rf_rdata[7:0];
        rx_stat_out <= rf_rdata[9:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event pulses, each gated by its mask bit
  always @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      ev_out <= {`EHL_EV_W{1'b0}};
      tlow_prev_q <= 8'h00;
      rnf_prev_q <= 8'h00;
    end
    else if (ce_in)
    begin
      tlow_prev_q <= tf_lvl;
      rnf_prev_q <= rf_lvl;
      ev_out <= ev_mask_in & (ev & {`EHL_EV_W{tb}} |
        ({`EHL_EV_W{1'b1}} & (
        ((rf_lvl >= rx_nf_in && rnf_prev_q < rx_nf_in) ? 10'h001 : 10'h000) |
        ((rb && rwr && rf_full) ? 10'h002 : 10'h000) |
        ((tf_lvl <= tx_low_in && tlow_prev_q > tx_low_in) ? 10'h004 : 10'h000) |
        ((rb && fend) ? 10'h020 : 10'h000) |
        ((rb && ((fend && fbad) || (rabt && rin_q && !rdrop_q))) ? 10'h040 : 10'h000) |
        ((rb && rabt && rin_q && !rdrop_q) ? 10'h080 : 10'h000) |
        ((rb && rbit && {hist_q[13:0], rbit} == `EHL_GA_PAT) ? 10'h100 : 10'h000) |
        ((hrd && rf_rdata[9:8] != `EHL_ST_DATA) ? 10'h200 : 10'h000))));
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// top level: one controller slice per link, shared framer timing
module ehl_top #(
  parameter NCH = 3
)(
  // clock, reset, enable
  input wire mclk_in,
  input wire nrst_in,
  input wire ce_in,
  // framer timing, shared by all controllers
  input wire fr_stb_in,
  input wire fr_e1_in,
  input wire [4:0] fr_slot_in,
  input wire [2:0] fr_bit_in,
  input wire fr_fdl_in,
  input wire fr_nfas_in,
  input wire rx_line_in,
  // data link selection, first controller only
  input wire dl_sel_in,
  input wire [4:0] nat_mask_in,
  // per-controller configuration, controller n in slice n
  input wire [NCH*5-1:0] tx_slot_in,
  input wire [NCH*5-1:0] rx_slot_in,
  input wire [NCH-1:0] tx_56_in,
  input wire [NCH-1:0] rx_56_in,
  input wire [NCH-1:0] tx_en_in,
  input wire [NCH-1:0] rx_en_in,
  input wire [NCH-1:0] flag_idle_in,
  input wire [NCH-1:0] fcs_inh_in,
  input wire [NCH-1:0] cnt_en_in,
  input wire [NCH*16-1:0] cnt_len_in,
  input wire [NCH*2-1:0] addr_mode_in,
  input wire [NCH*16-1:0] addr_in,
  input wire [NCH-1:0] lb_tx2rx_in,
  input wire [NCH-1:0] lb_rx2tx_in,
  input wire [NCH-1:0] fast_acc_in,
  input wire [NCH*3-1:0] tx_depth_in,
  input wire [NCH*3-1:0] rx_depth_in,
  input wire [NCH*8-1:0] tx_low_in,
  input wire [NCH*8-1:0] rx_nf_in,
  input wire [NCH*`EHL_EV_W-1:0] ev_mask_in,
  input wire [NCH-1:0] abort_cmd_in,
  // host fifo access
  input wire [NCH-1:0] tx_wr_in,
  input wire [NCH*8-1:0] tx_data_in,
  input wire [NCH-1:0] tx_eop_in,
  input wire [NCH-1:0] rx_rd_in,
  output wire [NCH*8-1:0] rx_data_out,
  output wire [NCH*2-1:0] rx_stat_out,
  output wire [NCH*16-1:0] rx_fcs_out,
  output wire [NCH*8-1:0] tx_level_out,
  output wire [NCH*8-1:0] rx_level_out,
  // framer transmit side and events
  output wire [NCH-1:0] tx_line_out,
  output wire [NCH-1:0] tx_take_out,
  output wire [NCH*`EHL_EV_W-1:0] ev_out
);
  genvar g;
  // one controller per slice; only the first may take the data link bits
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_ch
      wire dl = (g == 0) ? dl_sel_in : 1'b0;
      ehl_chan u_ch (
        .mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(ce_in),
        .fr_stb_in(fr_stb_in), .fr_e1_in(fr_e1_in), .fr_slot_in(fr_slot_in), .fr_bit_in(fr_bit_in),
        .fr_fdl_in(fr_fdl_in), .fr_nfas_in(fr_nfas_in), .rx_line_in(rx_line_in),
        .dl_sel_in(dl), .nat_mask_in(nat_mask_in),
        .tx_slot_in(tx_slot_in[g*5 +: 5]), .rx_slot_in(rx_slot_in[g*5 +: 5]),
        .tx_56_in(tx_56_in[g]), .rx_56_in(rx_56_in[g]), .tx_en_in(tx_en_in[g]), .rx_en_in(rx_en_in[g]),
        .flag_idle_in(flag_idle_in[g]), .fcs_inh_in(fcs_inh_in[g]), .cnt_en_in(cnt_en_in[g]),
        .cnt_len_in(cnt_len_in[g*16 +: 16]), .addr_mode_in(addr_mode_in[g*2 +: 2]),
        .addr_in(addr_in[g*16 +: 16]), .lb_tx2rx_in(lb_tx2rx_in[g]), .lb_rx2tx_in(lb_rx2tx_in[g]),
        .fast_acc_in(fast_acc_in[g]), .tx_depth_in(tx_depth_in[g*3 +: 3]), .rx_depth_in(rx_depth_in[g*3 +: 3]),
        .tx_low_in(tx_low_in[g*8 +: 8]), .rx_nf_in(rx_nf_in[g*8 +: 8]),
        .ev_mask_in(ev_mask_in[g*`EHL_EV_W +: `EHL_EV_W]), .abort_cmd_in(abort_cmd_in[g]),
        .tx_wr_in(tx_wr_in[g]), .tx_data_in(tx_data_in[g*8 +: 8]), .tx_eop_in(tx_eop_in[g]),
        .rx_rd_in(rx_rd_in[g]), .rx_data_out(rx_data_out[g*8 +: 8]), .rx_stat_out(rx_stat_out[g*2 +: 2]),
        .rx_fcs_out(rx_fcs_out[g*16 +: 16]), .tx_level_out(tx_level_out[g*8 +: 8]),
        .rx_level_out(rx_level_out[g*8 +: 8]), .tx_line_out(tx_line_out[g]), .tx_take_out(tx_take_out[g]),
        .ev_out(ev_out[g*`EHL_EV_W +: `EHL_EV_W])
      );
    end
  endgenerate
endmodule

// *** testbench.sv ***
// testbench: host loads a packet, looped back frame is read and judged
`timescale 1ns/1ns
`include "ehl_defs.vh"
module testbench;
  reg mclk_in, nrst_in, ce_in, fr_e1_in, fr_fdl_in, fr_nfas_in, dl_sel_in;
  reg [4:0] nat_mask_in;
  reg [14:0] tx_slot_in, rx_slot_in;
  reg [2:0] tx_56_in, rx_56_in, tx_en_in, rx_en_in, flag_idle_in, fcs_inh_in, cnt_en_in;
  reg [2:0] lb_tx2rx_in, lb_rx2tx_in, fast_acc_in, abort_cmd_in, tx_wr_in, tx_eop_in, rx_rd_in;
  reg [47:0] cnt_len_in, addr_in;
  reg [5:0] addr_mode_in;
  reg [8:0] tx_depth_in, rx_depth_in;
  reg [23:0] tx_low_in, rx_nf_in, tx_data_in;
  reg [29:0] ev_mask_in;
  wire fr_stb_in, rx_line_in;
  wire [4:0] fr_slot_in;
  wire [2:0] fr_bit_in, tx_line_out, tx_take_out;
  wire [23:0] rx_data_out, tx_level_out, rx_level_out;
  wire [5:0] rx_stat_out;
  wire [47:0] rx_fcs_out;
  wire [29:0] ev_out;
  integer miscompares = 0, compares = 0, cycles = 0, i;
  reg seen_eop;
  ehl_top dut (.*);
  ehl_framer_model u_fr (.mclk_in(mclk_in), .nrst_in(nrst_in), .fr_stb_out(fr_stb_in),
    .fr_slot_out(fr_slot_in), .fr_bit_out(fr_bit_in), .rx_line_out(rx_line_in));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    mclk_in = 0;
    forever #20 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  task final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares = compares + 1;
    if (g !== e)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // reference check sequence over two bytes, first byte in the low half, lsb first
  function [15:0] crc_ref(input [15:0] d);
    integer k;
    reg [15:0] c;
    begin
      c = `EHL_CRC_INIT;
      for (k = 0; k < 16; k = k + 1)
        c = (c >> 1) ^ ((c[0] ^ d[k]) ? `EHL_CRC_POLY : 16'h0000);
      crc_ref = c;
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // host accesses keep the slow four-cycle spacing before each request
  task wr(input [7:0] d, input e);
    repeat (3) @(negedge mclk_in);
    tx_wr_in[0] = 1;
    tx_data_in[7:0] = d;
    tx_eop_in[0] = e;
    @(negedge mclk_in) tx_wr_in[0] = 0;
  endtask
  task rd;
    repeat (3) @(negedge mclk_in);
    rx_rd_in[0] = 1;
    @(negedge mclk_in) rx_rd_in[0] = 0;
  endtask
  task t_spacing;
    @(negedge mclk_in) tx_wr_in[0] = 1;
    tx_data_in[7:0] = 8'hA5;
    @(negedge mclk_in) tx_data_in[7:0] = 8'h99;
    @(negedge mclk_in) tx_wr_in[0] = 0;
    chk("tx fill refused", 16'h1, tx_level_out[7:0]);
    wr(8'h3C, 1);
    chk("tx fill", 16'h2, tx_level_out[7:0]);
  endtask
  task t_frame;
    seen_eop = 0;
    @(negedge mclk_in) tx_en_in[0] = 1;
    for (i = 0; i < 5000 && ev_out[5] !== 1'b1; i = i + 1)
    begin
      @(posedge mclk_in) #1;
      if (ev_out[4] === 1'b1)
        seen_eop = 1;
    end
    chk("rx end event", 16'h1, ev_out[5]);
    chk("rx check sequence", ~crc_ref({8'h3C, 8'hA5}), rx_fcs_out[15:0]);
    chk("tx end event", 16'h1, seen_eop);
    rd;
    chk("first byte", 16'hA5, rx_data_out[7:0]);
    chk("first status", 16'h0, rx_stat_out[1:0]);
    rd;
    chk("last byte", 16'h3C, rx_data_out[7:0]);
    chk("last status good", 16'h1, rx_stat_out[1:0]);
    chk("end read event", 16'h1, ev_out[9]);
    chk("rx fill", 16'h0, rx_level_out[7:0]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: controller 0 in E1 timeslot 1, looped back inside
  initial
  begin
    {nrst_in, fr_e1_in, fr_fdl_in, fr_nfas_in, dl_sel_in, nat_mask_in} = 10'h100;
    {tx_56_in, rx_56_in, tx_en_in, fcs_inh_in, cnt_en_in, lb_rx2tx_in, fast_acc_in} = 21'h0;
    {abort_cmd_in, tx_wr_in, tx_eop_in, rx_rd_in, cnt_len_in, addr_in, addr_mode_in} = 0;
    {tx_data_in, tx_low_in, rx_nf_in} = {24'h0, 24'h010101, 24'h404040};
    {tx_slot_in, rx_slot_in, rx_en_in, flag_idle_in, lb_tx2rx_in} = {15'h1, 15'h1, 9'h1FF};
    {ce_in, tx_depth_in, rx_depth_in, ev_mask_in} = {19'h7FFFF, 30'h3FFFFFFF};
    repeat (12) @(negedge mclk_in);
    nrst_in = 1;
    chk("idle line", 16'h7, tx_line_out);
    t_spacing;
    t_frame;
    final_report;
  end
endmodule
